// ---- nand_host_pkg.sv ----
/*
  Constants, command bytes, timing counts and carrier types for the
  NAND target command controller.
  Assumes a 100 MHz i_mclk and an asynchronous x8 NAND target on the pins.
*/
// Summary of operation
// - Reset first after power-up, busy 1ms
// - Page load polled by plain status only
// - Reissue parameter page for next copy
// - Set features waits delay, writes four bytes
// - Status mode holds until read mode
// - With correction on, host reads status; the controller only reports the setting on o_ecc_on and reads no status itself
// - Enhanced status barred after reset/ID/config
// - Command latched on write strobe rising edge
package nand_host_pkg;

  // ==========================================================
  // Command and address bytes
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
  localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
  localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] ID_ADDR_SIG = 8'h20;
  localparam logic [7:0] FEAT_ADDR_ECC = 8'h90;
  localparam int ECC_EN_BIT = 0;

  // ==========================================================
  // Transfer lengths in bytes
  localparam logic [7:0] ID_MAKER_LEN = 8'h05;
  localparam logic [7:0] ID_SIG_LEN = 8'h04;
  localparam logic [7:0] UNIQUE_ID_LEN = 8'h10;
  localparam logic [7:0] FEAT_LEN = 8'h04;
  localparam logic [7:0] ROW_ADDR_CYCLES = 8'h03;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // ==========================================================
  // Timing, in ns or us, and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int NS_PER_US = 1000;
  localparam int T_STROBE_NS = 25;
  localparam int T_TURN_NS = 70;
  localparam int T_WB_NS = 100;
  localparam int T_POR_US = 1000;
  localparam int SYNC_LAG = 4;
  localparam logic [7:0] STROBE_CYC =
    8'((T_STROBE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] W_LAST_CYC = 8'(2 * STROBE_CYC - 1);
  localparam logic [7:0] RD_LOW_CYC = 8'(STROBE_CYC + SYNC_LAG);
  localparam logic [7:0] RD_SAMPLE_CYC = 8'(RD_LOW_CYC - 1);
  localparam logic [7:0] RD_LAST_CYC = 8'(RD_LOW_CYC + STROBE_CYC - 1);
  localparam logic [19:0] TURN_CYC =
    20'((T_TURN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [19:0] WB_CYC =
    20'((T_WB_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam int POR_BUSY_CYC = T_POR_US * CLK_MHZ;

  // ==========================================================
  // Carrier types
  typedef enum logic [3:0] {
    OP_RESET, OP_READ_ID, OP_PARAM_PAGE, OP_UNIQUE_ID, OP_GET_FEAT,
    OP_SET_FEAT, OP_STATUS, OP_STATUS_ENH, OP_READ_MODE
  } op_e;

  typedef struct packed {
    op_e op;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic [7:0] rd_len;
  } req_s;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] n_addr;
    logic [7:0] n_wdata;
    logic wait_busy;
    logic [7:0] n_rd;
  } op_info_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] io_o;
    logic io_oe;
  } pins_s;

endpackage

// ---- nand_host_ctrl.sv ----
/*
  Host controller for an asynchronous x8 NAND target: reset, ID reads,
  parameter page, unique ID, feature get/set and status commands.
  Assumes one 100 MHz clock, pins synchronised here, one request at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl #(
  parameter int TIMEOUT_CYC = nand_host_pkg::POR_BUSY_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire nand_host_pkg::req_s i_req,
  output logic o_req_ready,
  output nand_host_pkg::pins_s o_pins,
  input wire logic [7:0] i_io,
  input wire logic i_rb_n,
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte,
  output logic o_done,
  output logic o_refused,
  output logic o_timeout,
  output logic o_por_done,
  output logic o_ecc_on
);

  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_CMD, ST_ADDR, ST_TURN, ST_WDATA, ST_WB, ST_BUSY,
    ST_RDATA
  } state_e;

  localparam logic [19:0] TIMEOUT_LAST = 20'(TIMEOUT_CYC - 1);

  function automatic nand_host_pkg::op_info_s op_decode(
    input nand_host_pkg::req_s r
  );
    nand_host_pkg::op_info_s f;
    f = '0;
    case (r.op)
      nand_host_pkg::OP_RESET: begin
        f.cmd = nand_host_pkg::CMD_RESET;
        f.wait_busy = 1'b1;
      end
      nand_host_pkg::OP_READ_ID: begin
        f.cmd = nand_host_pkg::CMD_READ_ID;
        f.n_addr = nand_host_pkg::ONE_BYTE;
        f.n_rd = (r.addr[7:0] == nand_host_pkg::ID_ADDR_SIG) ?
          nand_host_pkg::ID_SIG_LEN : nand_host_pkg::ID_MAKER_LEN;
      end
      nand_host_pkg::OP_PARAM_PAGE: begin
        f.cmd = nand_host_pkg::CMD_PARAM_PAGE;
        f.n_addr = nand_host_pkg::ONE_BYTE;
        f.wait_busy = 1'b1;
        f.n_rd = r.rd_len;
      end
      nand_host_pkg::OP_UNIQUE_ID: begin
        f.cmd = nand_host_pkg::CMD_UNIQUE_ID;
        f.n_addr = nand_host_pkg::ONE_BYTE;
        f.wait_busy = 1'b1;
        f.n_rd = nand_host_pkg::UNIQUE_ID_LEN;
      end
      nand_host_pkg::OP_GET_FEAT: begin
        f.cmd = nand_host_pkg::CMD_GET_FEAT;
        f.n_addr = nand_host_pkg::ONE_BYTE;
        f.wait_busy = 1'b1;
        f.n_rd = nand_host_pkg::FEAT_LEN;
      end
      nand_host_pkg::OP_SET_FEAT: begin
        f.cmd = nand_host_pkg::CMD_SET_FEAT;
        f.n_addr = nand_host_pkg::ONE_BYTE;
        f.n_wdata = nand_host_pkg::FEAT_LEN;
        f.wait_busy = 1'b1;
      end
      nand_host_pkg::OP_STATUS: begin
        f.cmd = nand_host_pkg::CMD_STATUS;
        f.n_rd = nand_host_pkg::ONE_BYTE;
      end
      nand_host_pkg::OP_STATUS_ENH: begin
        f.cmd = nand_host_pkg::CMD_STATUS_ENH;
        f.n_addr = nand_host_pkg::ROW_ADDR_CYCLES;
        f.n_rd = nand_host_pkg::ONE_BYTE;
      end
      nand_host_pkg::OP_READ_MODE: begin
        f.cmd = nand_host_pkg::CMD_READ_MODE;
        f.n_rd = r.rd_len;
      end
      default: f = '0;
    endcase
    return f;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [7:0] io_s1_ff, io_s2_ff;
  logic rb_s1_ff, rb_s2_ff;

  always_ff @(posedge i_mclk) begin
    io_s1_ff <= i_io;
    io_s2_ff <= io_s1_ff;
    rb_s1_ff <= i_rb_n;
    rb_s2_ff <= rb_s1_ff;
  end

  // ==========================================================
  // Sequencer
  state_e state_ff, nxt_state;
  nand_host_pkg::req_s req_ff, nxt_req;
  nand_host_pkg::op_info_s info_ff, nxt_info;
  nand_host_pkg::pins_s pins_ff, nxt_pins;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] idx_ff, nxt_idx;
  logic [19:0] tmr_ff, nxt_tmr;
  logic [7:0] rd_byte_ff, nxt_rd_byte;
  logic rd_valid_ff, nxt_rd_valid;
  logic done_ff, nxt_done;
  logic refused_ff, nxt_refused;
  logic timeout_ff, nxt_timeout;
  logic por_done_ff, nxt_por_done;
  logic enh_block_ff, nxt_enh_block;
  logic ecc_on_ff, nxt_ecc_on;
  logic fin;

  always_comb begin
    nxt_state = state_ff;
    nxt_req = req_ff;
    nxt_info = info_ff;
    nxt_cnt = cnt_ff + 8'h01;
    nxt_idx = idx_ff;
    nxt_tmr = tmr_ff;
    nxt_rd_byte = rd_byte_ff;
    nxt_rd_valid = 1'b0;
    nxt_done = 1'b0;
    nxt_refused = 1'b0;
    nxt_timeout = 1'b0;
    nxt_por_done = por_done_ff;
    nxt_enh_block = enh_block_ff;
    nxt_ecc_on = ecc_on_ff;
    fin = 1'b0;
    nxt_pins = '0;
    nxt_pins.ce_n = 1'b1;
    nxt_pins.we_n = 1'b1;
    nxt_pins.re_n = 1'b1;
    case (state_ff)
      ST_INIT: begin
        // Power-up reset is forced before any user request
        nxt_req = '0;
        nxt_req.op = nand_host_pkg::OP_RESET;
        nxt_info = op_decode(nxt_req);
        nxt_state = ST_CMD;
        nxt_cnt = '0;
      end
      ST_IDLE: begin
        nxt_cnt = '0;
        if (i_req_valid) begin
          if (i_req.op == nand_host_pkg::OP_STATUS_ENH &&
              (!por_done_ff || enh_block_ff)) begin
            nxt_refused = 1'b1;
          end else begin
            nxt_req = i_req;
            nxt_info = op_decode(i_req);
            nxt_state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.cle = 1'b1;
        nxt_pins.we_n = (cnt_ff >= nand_host_pkg::STROBE_CYC);
        nxt_pins.io_o = info_ff.cmd;
        nxt_pins.io_oe = 1'b1;
        if (cnt_ff == nand_host_pkg::W_LAST_CYC) begin
          nxt_cnt = '0;
          nxt_idx = '0;
          nxt_tmr = '0;
          if (info_ff.n_addr != '0) begin
            nxt_state = ST_ADDR;
          end else if (info_ff.wait_busy) begin
            nxt_state = ST_WB;
          end else if (info_ff.n_rd != '0) begin
            nxt_state = ST_TURN;
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_ADDR: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.ale = 1'b1;
        nxt_pins.we_n = (cnt_ff >= nand_host_pkg::STROBE_CYC);
        nxt_pins.io_o = req_ff.addr[{idx_ff[1:0], 3'b000} +: 8];
        nxt_pins.io_oe = 1'b1;
        if (cnt_ff == nand_host_pkg::W_LAST_CYC) begin
          nxt_cnt = '0;
          nxt_idx = idx_ff + 8'h01;
          nxt_tmr = '0;
          if (idx_ff == info_ff.n_addr - 8'h01) begin
            nxt_idx = '0;
            if (info_ff.n_wdata == '0 && info_ff.wait_busy) begin
              nxt_state = ST_WB;
            end else begin
              nxt_state = ST_TURN;
            end
          end
        end
      end
      ST_TURN: begin
        // Covers both address-to-data and command-to-read turnaround
        nxt_pins.ce_n = 1'b0;
        nxt_cnt = '0;
        nxt_tmr = tmr_ff + 20'h0_0001;
        if (tmr_ff == nand_host_pkg::TURN_CYC - 20'h0_0001) begin
          nxt_tmr = '0;
          nxt_state = (info_ff.n_wdata != '0) ? ST_WDATA : ST_RDATA;
        end
      end
      ST_WDATA: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.we_n = (cnt_ff >= nand_host_pkg::STROBE_CYC);
        nxt_pins.io_o = req_ff.wdata[{idx_ff[1:0], 3'b000} +: 8];
        nxt_pins.io_oe = 1'b1;
        if (cnt_ff == nand_host_pkg::W_LAST_CYC) begin
          nxt_cnt = '0;
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == info_ff.n_wdata - 8'h01) begin
            nxt_idx = '0;
            nxt_tmr = '0;
            nxt_state = ST_WB;
          end
        end
      end
      ST_WB: begin
        // Busy line may lag the last strobe; wait before trusting it
        nxt_pins.ce_n = 1'b0;
        nxt_cnt = '0;
        nxt_tmr = tmr_ff + 20'h0_0001;
        if (tmr_ff == nand_host_pkg::WB_CYC - 20'h0_0001) begin
          nxt_tmr = '0;
          nxt_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // No other command is sent while the target is busy
        nxt_pins.ce_n = 1'b0;
        nxt_cnt = '0;
        nxt_tmr = tmr_ff + 20'h0_0001;
        if (rb_s2_ff) begin
          nxt_idx = '0;
          if (info_ff.n_rd != '0) begin
            nxt_state = ST_RDATA;
          end else begin
            fin = 1'b1;
          end
        end else if (tmr_ff == TIMEOUT_LAST) begin
          nxt_timeout = 1'b1;
          fin = 1'b1;
        end
      end
      ST_RDATA: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.re_n = (cnt_ff >= nand_host_pkg::RD_LOW_CYC);
        if (cnt_ff == nand_host_pkg::RD_SAMPLE_CYC) begin
          nxt_rd_byte = io_s2_ff;
          nxt_rd_valid = 1'b1;
        end
        if (cnt_ff == nand_host_pkg::RD_LAST_CYC) begin
          nxt_cnt = '0;
          nxt_idx = idx_ff + 8'h01;
          if (idx_ff == info_ff.n_rd - 8'h01) begin
            fin = 1'b1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (fin) begin
      nxt_state = ST_IDLE;
      nxt_done = 1'b1;
      nxt_cnt = '0;
      nxt_pins.ce_n = 1'b1;
      case (req_ff.op)
        nand_host_pkg::OP_RESET: begin
          nxt_por_done = 1'b1;
          nxt_enh_block = 1'b1;
        end
        nand_host_pkg::OP_READ_ID, nand_host_pkg::OP_PARAM_PAGE,
        nand_host_pkg::OP_UNIQUE_ID, nand_host_pkg::OP_GET_FEAT: begin
          nxt_enh_block = 1'b1;
        end
        nand_host_pkg::OP_SET_FEAT: begin
          nxt_enh_block = 1'b1;
          if (req_ff.addr[7:0] == nand_host_pkg::FEAT_ADDR_ECC) begin
            nxt_ecc_on = req_ff.wdata[nand_host_pkg::ECC_EN_BIT];
          end
        end
        nand_host_pkg::OP_STATUS: begin
          nxt_enh_block = 1'b0;
        end
        default: begin
          nxt_enh_block = enh_block_ff;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_ff <= ST_INIT;
      req_ff <= '0;
      info_ff <= '0;
      pins_ff <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                   re_n: 1'b1, io_o: 8'h00, io_oe: 1'b0};
      cnt_ff <= '0;
      idx_ff <= '0;
      tmr_ff <= '0;
      rd_byte_ff <= '0;
      rd_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      refused_ff <= 1'b0;
      timeout_ff <= 1'b0;
      por_done_ff <= 1'b0;
      enh_block_ff <= 1'b0;
      ecc_on_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      info_ff <= nxt_info;
      pins_ff <= nxt_pins;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      tmr_ff <= nxt_tmr;
      rd_byte_ff <= nxt_rd_byte;
      rd_valid_ff <= nxt_rd_valid;
      done_ff <= nxt_done;
      refused_ff <= nxt_refused;
      timeout_ff <= nxt_timeout;
      por_done_ff <= nxt_por_done;
      enh_block_ff <= nxt_enh_block;
      ecc_on_ff <= nxt_ecc_on;
    end
  end

  assign o_req_ready = (state_ff == ST_IDLE);
  assign o_pins = pins_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_rd_byte = rd_byte_ff;
  assign o_done = done_ff;
  assign o_refused = refused_ff;
  assign o_timeout = timeout_ff;
  assign o_por_done = por_done_ff;
  assign o_ecc_on = ecc_on_ff;

endmodule
`default_nettype wire

// ---- nand_dev_model.sv ----
/*
  Behavioural x8 NAND target for the host controller bench.
  Assumes the bench resolves the IO wire and pulls ready/busy up.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
  parameter int T_BUSY_NS = 300
) (
  input wire nand_host_pkg::pins_s i_pins,
  input wire logic [7:0] i_io,
  input wire logic i_slow,
  output logic [7:0] o_io,
  output logic o_io_oe,
  output logic o_busy
);
  logic [31:0] feat [0:255] = '{default: 32'h0000_0000};
  logic [31:0] wbuf = 32'h0000_0000;
  logic [7:0] cmd = 8'h00;
  logic [7:0] fa = 8'h00;
  logic [7:0] copy = 8'h00;
  logic stat = 1'b0;
  int ptr = 0;
  int nw = 0;
  int rdy_t = 0;
  initial o_busy = 1'b0;
  initial o_io = 8'h00;
  assign o_io_oe = !i_pins.ce_n && !i_pins.re_n;
  // Slow mode outlasts the host timeout on purpose
  task automatic go_busy(input int ns);
    o_busy = 1'b1;
    rdy_t = $time + (i_slow ? 5000 : ns);
  endtask
  always #5 if (o_busy && $time >= rdy_t) o_busy = 1'b0;
  function automatic logic [7:0] dout();
    case (cmd)
      nand_host_pkg::CMD_READ_ID:
        return (fa == 8'h20 ? 8'hB0 : 8'hA0) + 8'(ptr);
      nand_host_pkg::CMD_PARAM_PAGE:
        return {copy[3:0], 4'h0} + 8'(ptr);
      nand_host_pkg::CMD_UNIQUE_ID: return 8'hC0 + 8'(ptr);
      nand_host_pkg::CMD_GET_FEAT: return 8'(feat[fa] >> (8 * ptr));
      default: return 8'h00;
    endcase
  endfunction
  // ==========================================================
  // Write strobe: command, address, data
  always @(posedge i_pins.we_n) begin
    if (!i_pins.ce_n && i_pins.cle && (!o_busy ||
        i_io inside {8'h70, 8'h78, 8'hFF})) begin
      case (i_io)
        8'h70, 8'h78: stat = 1'b1;
        8'h00: stat = 1'b0;
        8'hFF, 8'h90, 8'hEC, 8'hED, 8'hEE, 8'hEF: begin
          cmd = i_io;
          stat = 1'b0;
          ptr = 0;
          nw = 0;
          if (i_io == 8'hFF) go_busy(T_BUSY_NS);
        end
        default: ;
      endcase
    end else if (!i_pins.ce_n && i_pins.ale && !o_busy && !stat) begin
      fa = i_io;
      if (cmd inside {8'hEC, 8'hED, 8'hEE}) begin
        go_busy(T_BUSY_NS);
      end
      if (cmd == 8'hEC) copy = copy + 8'h01;
    end else if (!i_pins.ce_n && !i_pins.ale && !i_pins.cle && !o_busy &&
        cmd == 8'hEF && nw < 4) begin
      wbuf = {i_io, wbuf[31:8]};
      nw++;
      if (nw == 4) begin
        go_busy((fa == 8'h01 && wbuf[7:0] != feat[1][7:0]) ?
          2 * T_BUSY_NS : T_BUSY_NS);
        feat[fa] = wbuf;
      end
    end
  end
  always @(negedge i_pins.re_n) if (!i_pins.ce_n) begin
    o_io = stat ? (o_busy ? 8'h00 : 8'hE0) : dout();
    if (!stat) ptr++;
  end
endmodule
`default_nettype wire

// ---- nand_host_ctrl_chk.sv ----
/*
  Port assertions for the NAND host controller.
  Assumes it is bound onto every nand_host_ctrl instance.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl_chk #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic o_req_ready,
  input wire nand_host_pkg::pins_s o_pins,
  input wire logic o_rd_valid,
  input wire logic o_done,
  input wire logic o_refused,
  input wire logic o_timeout,
  input wire logic o_por_done
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_cmd_latch; $rose(o_pins.we_n) && o_pins.cle |->
    !o_pins.ce_n && !o_pins.ale && o_pins.re_n && o_pins.io_oe; endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("cmd");
  property p_wr_hold; $rose(o_pins.we_n) |->
    $stable(o_pins.io_o) && o_pins.io_oe && !o_pins.ce_n; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write hold");
  property p_we_width; $fell(o_pins.we_n) |->
    !o_pins.we_n [*3] ##1 o_pins.we_n; endproperty
  a_we_width: assert property (p_we_width) else $error("we width");
  property p_rd_mode; !o_pins.re_n |-> !o_pins.io_oe && o_pins.we_n &&
    !o_pins.cle && !o_pins.ale && !o_pins.ce_n; endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("read mode");
  property p_por_first; !o_por_done |-> !o_req_ready; endproperty
  a_por_first: assert property (p_por_first) else $error("por");
  property p_refuse; o_refused |-> o_pins.ce_n && !o_done; endproperty
  a_refuse: assert property (p_refuse) else $error("refuse");
  property p_tmo; o_timeout |-> o_done && !o_rd_valid; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout");
  property p_ready; o_done |=> o_req_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready");
  c_refused: cover property (o_refused);
  c_timeout: cover property (o_timeout);
  c_read: cover property (o_rd_valid ##1 !o_rd_valid);
endmodule
bind nand_host_ctrl nand_host_ctrl_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
  .i_mclk, .i_rst, .o_req_ready, .o_pins, .o_rd_valid, .o_done,
  .o_refused, .o_timeout, .o_por_done);
`default_nettype wire

// ---- tb.sv ----
/*
  Self-checking bench for the NAND host controller.
  Assumes the device model stands on the pins; ready/busy is pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic valid = 1'b0;
  logic slow = 1'b0;
  nand_host_pkg::req_s req = '0;
  nand_host_pkg::pins_s pins;
  logic [7:0] io, dev_io, rd_byte;
  logic dev_oe, busy, rb_n, ready, rd_valid, done, refused, tmo, por, ecc;
  logic [7:0] got [0:15];
  int got_n, err_count = 0, check_count = 0;
  logic saw_ref, saw_tmo;
  // Released IO shows the inverse so stale data cannot pass
  assign io = pins.io_oe ? pins.io_o : dev_oe ? dev_io : ~dev_io;
  assign rb_n = !busy;
  nand_host_ctrl #(.TIMEOUT_CYC(200)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_req_valid(valid), .i_req(req), .o_req_ready(ready), .o_pins(pins),
    .i_io(io), .i_rb_n(rb_n), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte),
    .o_done(done), .o_refused(refused), .o_timeout(tmo),
    .o_por_done(por), .o_ecc_on(ecc));
  nand_dev_model dev_u (.i_pins(pins), .i_io(io), .i_slow(slow),
    .o_io(dev_io), .o_io_oe(dev_oe), .o_busy(busy));
  initial forever #5 i_mclk = ~i_mclk;
  // ==========================================================
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input nand_host_pkg::op_e op, input logic [7:0] a,
    input logic [31:0] w, input logic [7:0] len);
    int n;
    req <= '{op, {16'h0000, a}, w, len};
    valid <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (ready !== 1'b1 && n < 300);
    valid <= 1'b0;
    if (ready !== 1'b1) begin
      err_count++;
      complete_run();
    end
    got_n = 0;
    saw_tmo = 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(posedge i_mclk);
      if (rd_valid === 1'b1 && got_n < 16) got[got_n++] = rd_byte;
      saw_tmo = saw_tmo | (tmo === 1'b1);
      if (done === 1'b1 || refused === 1'b1) break;
    end
    saw_ref = (refused === 1'b1);
    if (n >= 20000) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic seq(input string what, input int n, input logic [7:0] b);
    check(what, got_n, n);
    for (int k = 0; k < n; k++) check(what, got[k], b + 8'(k));
  endtask
  task automatic wait_rdy(input logic lvl_por);
    int n;
    for (n = 0; n < 2000 && (lvl_por ? por : rb_n) !== 1'b1; n++)
      @(posedge i_mclk);
    if (n >= 2000) begin
      err_count++;
      complete_run();
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_por();
    wait_rdy(1'b1);
    check("ready", ready, 1'b1);
    check("ecc", ecc, 1'b0);
    $display("test por done");
  endtask
  task automatic t_ids();
    xfer(nand_host_pkg::OP_READ_ID, 8'h00, 32'h0000_0000, 8'h00);
    seq("id", 5, 8'hA0);
    xfer(nand_host_pkg::OP_READ_ID, 8'h20, 32'h0000_0000, 8'h00);
    seq("sig", 4, 8'hB0);
    xfer(nand_host_pkg::OP_UNIQUE_ID, 8'h00, 32'h0000_0000, 8'h00);
    seq("uid", 16, 8'hC0);
    $display("test ids done");
  endtask
  task automatic t_page();
    xfer(nand_host_pkg::OP_PARAM_PAGE, 8'h00, 32'h0000_0000, 8'h02);
    seq("page", 2, 8'h10);
    xfer(nand_host_pkg::OP_STATUS, 8'h00, 32'h0000_0000, 8'h00);
    seq("status", 1, 8'hE0);
    xfer(nand_host_pkg::OP_READ_MODE, 8'h00, 32'h0000_0000, 8'h02);
    seq("resume", 2, 8'h12);
    xfer(nand_host_pkg::OP_PARAM_PAGE, 8'h00, 32'h0000_0000, 8'h02);
    seq("copy", 2, 8'h20);
    $display("test page done");
  endtask
  task automatic t_feat();
    xfer(nand_host_pkg::OP_SET_FEAT, 8'h90, 32'h0000_0001, 8'h00);
    check("ecc on", ecc, 1'b1);
    xfer(nand_host_pkg::OP_SET_FEAT, 8'h01, 32'h0000_0002, 8'h00);
    check("mode tmo", saw_tmo, 1'b0);
    check("mode busy", rb_n, 1'b1);
    xfer(nand_host_pkg::OP_STATUS_ENH, 8'h00, 32'h0000_0000, 8'h00);
    check("enh bar", saw_ref, 1'b1);
    xfer(nand_host_pkg::OP_STATUS, 8'h00, 32'h0000_0000, 8'h00);
    xfer(nand_host_pkg::OP_STATUS_ENH, 8'h00, 32'h0000_0000, 8'h00);
    check("enh ok", saw_ref, 1'b0);
    seq("enh", 1, 8'hE0);
    xfer(nand_host_pkg::OP_RESET, 8'h00, 32'h0000_0000, 8'h00);
    check("rst tmo", saw_tmo, 1'b0);
    check("rst busy", rb_n, 1'b1);
    check("ecc kept", ecc, 1'b1);
    xfer(nand_host_pkg::OP_GET_FEAT, 8'h90, 32'h0000_0000, 8'h00);
    check("feat", {got[3], got[2], got[1], got[0]},
      32'h0000_0001);
    $display("test feat done");
  endtask
  task automatic t_tmo();
    slow <= 1'b1;
    xfer(nand_host_pkg::OP_RESET, 8'h00, 32'h0000_0000, 8'h00);
    check("tmo", saw_tmo, 1'b1);
    slow <= 1'b0;
    wait_rdy(1'b0);
    xfer(nand_host_pkg::OP_STATUS, 8'h00, 32'h0000_0000, 8'h00);
    seq("after tmo", 1, 8'hE0);
    $display("test tmo done");
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_por();
    t_ids();
    t_page();
    t_feat();
    t_tmo();
    complete_run();
  end
endmodule
`default_nettype wire
